// File: rtl/hcam_monitor.sv
`timescale 1ns/1ps
`include "hcam_consts.svh"

// Summary of operation
// - burnout alarm when on-current below threshold
// - burnout threshold 0.0 off, 50.0 on
// - overcurrent alarm when on-current above threshold
// - overcurrent threshold 50.0 off, 0.0 on
// - leakage alarm when off-current above threshold
// - leakage threshold 50.0 off, 0.0 on
// - on-periods of 100 ms or less ignored
// - off-periods of 100 ms or less ignored
// - monitors show 0.0 to 55.0, else FFFF
// - leakage monitor captures off-state reading
// - burnout/overcurrent light lamp, flash heater display
// - leakage lights lamp, flashes leakage display
// - burnout needs enable and alarm output 1
// - overcurrent needs its enable and alarm output 1
// - leakage needs its enable and alarm output 1
// - second channel only with two inputs

module hcam_monitor #(
  parameter int unsigned SHORT_CYC = `HCAM_SHORT_MS * `HCAM_CLK_KHZ,
  parameter int unsigned BLINK_CYC = `HCAM_BLINK_MS * `HCAM_CLK_KHZ,
  parameter bit TWO_CT = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic heat_out_in,
  input wire logic ct_valid_in,
  input wire logic [15:0] ct1_current_in,
  input wire logic [15:0] ct2_current_in,
  input wire logic thr_load_in,
  input wire hcam_pkg::hcam_thr_s thr1_in,
  input wire hcam_pkg::hcam_thr_s thr2_in,
  input wire logic alarm1_assigned_in,
  input wire logic burnout_detect_enable_in,
  input wire logic overcurrent_enable_in,
  input wire logic leakage_enable_in,
  output logic [1:0] burnout_alarm_out,
  output logic [1:0] overcurrent_alarm_out,
  output logic [1:0] leakage_short_alarm_out,
  output logic heater_alarm_lamp_out,
  output logic [1:0] heater_mon_flash_out,
  output logic [1:0] leak_mon_flash_out,
  output logic [15:0] heater_current1_out,
  output logic [15:0] heater_current2_out,
  output logic [15:0] leakage_current1_out,
  output logic [15:0] leakage_current2_out
);

  // ****************************************
  // limits
  // ****************************************
  localparam logic [23:0] SHORT_LIM = 24'(SHORT_CYC);
  localparam logic [23:0] BLINK_LIM = 24'(BLINK_CYC - 1);

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic burn_hit(input logic [15:0] cur, input logic [8:0] thr);
    logic hit;
    if (thr == `HCAM_THR_MIN) begin
      hit = 1'b0;
    end else if (thr == `HCAM_THR_MAX) begin
      hit = 1'b1;
    end else begin
      hit = cur < {7'h00, thr};
    end
    return hit;
  endfunction

  function automatic logic above_hit(input logic [15:0] cur, input logic [8:0] thr);
    logic hit;
    if (thr == `HCAM_THR_MAX) begin
      hit = 1'b0;
    end else if (thr == `HCAM_THR_MIN) begin
      hit = 1'b1;
    end else begin
      hit = cur > {7'h00, thr};
    end
    return hit;
  endfunction

  function automatic logic [15:0] mon_code(input logic [15:0] cur);
    logic [15:0] code;
    if (cur > `HCAM_MON_MAX) begin
      code = `HCAM_OVERRANGE;
    end else begin
      code = cur;
    end
    return code;
  endfunction

  function automatic logic [8:0] thr_clip(input logic [8:0] thr);
    logic [8:0] val;
    if (thr > `HCAM_THR_MAX) begin
      val = `HCAM_THR_MAX;
    end else begin
      val = thr;
    end
    return val;
  endfunction

  // ****************************************
  // state
  // ****************************************
  hcam_pkg::hcam_state_s st;
  hcam_pkg::hcam_state_s next_st;

  logic ends_on;
  logic ends_off;
  logic qualified;
  logic [15:0] smp;
  hcam_pkg::hcam_thr_s thr_new;
  hcam_pkg::hcam_chan_s nc;
  logic any_alarm;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    smp = 16'h0000;
    thr_new = '0;
    nc = '0;
    any_alarm = 1'b0;
    ends_on = (st.phase == hcam_pkg::HCAM_ST_ON) && !heat_out_in;
    ends_off = (st.phase == hcam_pkg::HCAM_ST_OFF) && heat_out_in;
    qualified = st.period_cnt > SHORT_LIM;

    // period length, saturating just above the short limit
    if (st.period_cnt <= SHORT_LIM) begin
      next_st.period_cnt = st.period_cnt + 24'h000001;
    end

    case (st.phase)
      hcam_pkg::HCAM_ST_OFF: begin
        if (heat_out_in) begin
          next_st.phase = hcam_pkg::HCAM_ST_ON;
          next_st.period_cnt = 24'h000000;
        end
      end
      hcam_pkg::HCAM_ST_ON: begin
        if (!heat_out_in) begin
          next_st.phase = hcam_pkg::HCAM_ST_OFF;
          next_st.period_cnt = 24'h000000;
        end
      end
      default: begin
        next_st.phase = hcam_pkg::HCAM_ST_OFF;
        next_st.period_cnt = 24'h000000;
      end
    endcase

    // blink divider for the flashing displays
    if (st.blink_cnt >= BLINK_LIM) begin
      next_st.blink_cnt = 24'h000000;
      next_st.blink = !st.blink;
    end else begin
      next_st.blink_cnt = st.blink_cnt + 24'h000001;
    end

    for (int c = 0; c < 2; c++) begin
      nc = st.ch[c];
      smp = (c == 0) ? ct1_current_in : ct2_current_in;
      thr_new = (c == 0) ? thr1_in : thr2_in;

      if (thr_load_in) begin
        nc.thr.burn = thr_clip(thr_new.burn);
        nc.thr.over = thr_clip(thr_new.over);
        nc.thr.leak = thr_clip(thr_new.leak);
      end

      // latest sample of the running period
      if (ct_valid_in && st.phase == hcam_pkg::HCAM_ST_ON) begin
        nc.on_smp = smp;
        nc.on_got = 1'b1;
        nc.heat_mon = mon_code(smp);
      end
      if (ct_valid_in && st.phase == hcam_pkg::HCAM_ST_OFF) begin
        nc.off_smp = smp;
        nc.off_got = 1'b1;
        nc.leak_mon = mon_code(smp);
      end

      // judge at the end of the period
      if (ends_on) begin
        if (qualified && st.ch[c].on_got) begin
          nc.burn = burn_hit(st.ch[c].on_smp, st.ch[c].thr.burn);
          nc.over = above_hit(st.ch[c].on_smp, st.ch[c].thr.over);
        end
        nc.on_got = 1'b0;
      end
      if (ends_off) begin
        if (qualified && st.ch[c].off_got) begin
          nc.leak = above_hit(st.ch[c].off_smp, st.ch[c].thr.leak);
        end
        nc.off_got = 1'b0;
      end

      // enables drop the alarm at once
      if (!(burnout_detect_enable_in && alarm1_assigned_in)) begin
        nc.burn = 1'b0;
      end
      if (!(overcurrent_enable_in && alarm1_assigned_in)) begin
        nc.over = 1'b0;
      end
      if (!(leakage_enable_in && alarm1_assigned_in)) begin
        nc.leak = 1'b0;
        nc.leak_mon = 16'h0000;
        nc.off_got = 1'b0;
      end

      nc.heat_flash = (nc.burn || nc.over) && next_st.blink;
      nc.leak_flash = nc.leak && next_st.blink;

      if (c == 1 && !TWO_CT) begin
        nc = '0;
      end
      any_alarm = any_alarm || nc.burn || nc.over || nc.leak;
      next_st.ch[c] = nc;
    end

    next_st.lamp = any_alarm;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
      st.phase <= hcam_pkg::HCAM_ST_OFF;
      for (int c = 0; c < 2; c++) begin
        st.ch[c].thr.burn <= `HCAM_BURN_RST;
        st.ch[c].thr.over <= `HCAM_OVER_RST;
        st.ch[c].thr.leak <= `HCAM_LEAK_RST;
      end
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign burnout_alarm_out = {st.ch[1].burn, st.ch[0].burn};
  assign overcurrent_alarm_out = {st.ch[1].over, st.ch[0].over};
  assign leakage_short_alarm_out = {st.ch[1].leak, st.ch[0].leak};
  assign heater_alarm_lamp_out = st.lamp;
  assign heater_mon_flash_out = {st.ch[1].heat_flash, st.ch[0].heat_flash};
  assign leak_mon_flash_out = {st.ch[1].leak_flash, st.ch[0].leak_flash};
  assign heater_current1_out = st.ch[0].heat_mon;
  assign heater_current2_out = st.ch[1].heat_mon;
  assign leakage_current1_out = st.ch[0].leak_mon;
  assign leakage_current2_out = st.ch[1].leak_mon;

endmodule

// File: rtl/hcam_consts.svh
`ifndef HCAM_CONSTS_SVH
`define HCAM_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define HCAM_CLK_KHZ 50000
`define HCAM_SHORT_MS 100
`define HCAM_BLINK_MS 250
`define HCAM_CNT_W 24

// ****************************************
// current scale, tenths of an ampere
// ****************************************
`define HCAM_THR_MIN 9'h000
`define HCAM_THR_MAX 9'h1F4
`define HCAM_MON_MAX 16'h0226
`define HCAM_OVERRANGE 16'hFFFF

// ****************************************
// threshold reset values
// ****************************************
`define HCAM_BURN_RST 9'h000
`define HCAM_OVER_RST 9'h1F4
`define HCAM_LEAK_RST 9'h1F4

`endif

// File: rtl/hcam_pkg.sv
package hcam_pkg;

  // ****************************************
  // heating output phase
  // ****************************************
  typedef enum logic [1:0] {
    HCAM_ST_OFF = 2'b01,
    HCAM_ST_ON = 2'b10
  } hcam_phase_e;

  // ****************************************
  // thresholds of one channel, tenths of an ampere
  // ****************************************
  typedef struct packed {
    logic [8:0] burn;
    logic [8:0] over;
    logic [8:0] leak;
  } hcam_thr_s;

  // ****************************************
  // per channel state
  // ****************************************
  typedef struct packed {
    hcam_thr_s thr;
    logic [15:0] on_smp;
    logic on_got;
    logic [15:0] off_smp;
    logic off_got;
    logic [15:0] heat_mon;
    logic [15:0] leak_mon;
    logic burn;
    logic over;
    logic leak;
    logic heat_flash;
    logic leak_flash;
  } hcam_chan_s;

  // ****************************************
  // whole block state
  // ****************************************
  typedef struct packed {
    hcam_phase_e phase;
    logic [23:0] period_cnt;
    logic [23:0] blink_cnt;
    logic blink;
    logic lamp;
    hcam_chan_s [1:0] ch;
  } hcam_state_s;

endpackage

// File: tb/hcam_monitor_props.sv
`timescale 1ns/1ps

module hcam_monitor_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic heat_out_in,
  input wire logic burnout_detect_enable_in,
  input wire logic overcurrent_enable_in,
  input wire logic leakage_enable_in,
  input wire logic [1:0] burnout_alarm_out,
  input wire logic [1:0] overcurrent_alarm_out,
  input wire logic [1:0] leakage_short_alarm_out,
  input wire logic heater_alarm_lamp_out,
  input wire logic [1:0] heater_mon_flash_out,
  input wire logic [1:0] leak_mon_flash_out,
  input wire logic [15:0] heater_current1_out,
  input wire logic [15:0] leakage_current1_out
);
  // ****
  // checks
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  lamp_is_or_a: assert property (heater_alarm_lamp_out == |{burnout_alarm_out,
    overcurrent_alarm_out, leakage_short_alarm_out}) else $error("lamp mismatch");
  heat_flash_a: assert property ((heater_mon_flash_out & ~(burnout_alarm_out |
    overcurrent_alarm_out | $past(burnout_alarm_out | overcurrent_alarm_out))) == 2'b00)
    else $error("heater flash without alarm");
  leak_flash_a: assert property ((leak_mon_flash_out & ~(leakage_short_alarm_out |
    $past(leakage_short_alarm_out))) == 2'b00) else $error("leak flash without alarm");
  burn_enable_a: assert property (!burnout_detect_enable_in |=> burnout_alarm_out == 2'b00)
    else $error("burnout alarm while disabled");
  over_enable_a: assert property (!overcurrent_enable_in |=> overcurrent_alarm_out == 2'b00)
    else $error("overcurrent alarm while disabled");
  leak_enable_a: assert property (!leakage_enable_in |=> leakage_short_alarm_out == 2'b00 &&
    leakage_current1_out == 16'h0000) else $error("leakage active while disabled");
  mon_range_a: assert property ((heater_current1_out <= 16'h0226 ||
    heater_current1_out == 16'hFFFF) && (leakage_current1_out <= 16'h0226 ||
    leakage_current1_out == 16'hFFFF)) else $error("monitor out of range");
  on_end_only_a: assert property ($rose(burnout_alarm_out[0] | overcurrent_alarm_out[0])
    |-> $past(heat_out_in, 2) && !$past(heat_out_in)) else $error("alarm rose off period end");
endmodule

bind hcam_monitor hcam_monitor_props u_props (.*);

// File: tb/hcam_ct_model.sv
`timescale 1ns/1ps

module hcam_ct_model (
  input wire logic clk_in,
  input wire logic heat_in,
  input wire logic [1:0][15:0] on_in,
  input wire logic [1:0][15:0] off_in,
  output logic valid_out,
  output logic [15:0] ct1_out,
  output logic [15:0] ct2_out
);
  // ****
  // transformer readings
  // ****
  logic h = 1'b0;
  always @(posedge clk_in) begin
    h <= heat_in;
  end
  // output just switched: reading not settled, show garbage
  assign valid_out = h == heat_in;
  assign ct1_out = !valid_out ? ~on_in[0] : h ? on_in[0] : off_in[0];
  assign ct2_out = !valid_out ? ~on_in[1] : h ? on_in[1] : off_in[1];
endmodule

// File: tb/hcam_monitor_tb.sv
`timescale 1ns/1ps

module hcam_monitor_tb;
  // ****
  // bench
  // ****
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic heat = 1'b0;
  logic load = 1'b0;
  logic en_b = 1'b1;
  logic en_o = 1'b1;
  logic en_l = 1'b1;
  hcam_pkg::hcam_thr_s thr1 = '0;
  hcam_pkg::hcam_thr_s thr2 = '0;
  logic [1:0][15:0] on_v = '0;
  logic [1:0][15:0] off_v = '0;
  logic valid;
  logic [15:0] ct1, ct2, h1, h2, l1;
  logic [1:0] ba, oa, la;
  logic lamp;
  logic [15:0] al;
  logic asg = 1'b1;
  logic [1:0] hf, lf, fo, fa, lo, lz, ba2, oa2;
  logic [15:0] l2, hs2;
  int failures = 0;
  int n_checks = 0;
  assign al = {9'h000, lamp, ba, oa, la};

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  hcam_ct_model u_ct (.clk_in(clk_in), .heat_in(heat), .on_in(on_v), .off_in(off_v),
    .valid_out(valid), .ct1_out(ct1), .ct2_out(ct2));

  hcam_monitor #(.SHORT_CYC(20), .BLINK_CYC(4), .TWO_CT(1'b1)) DUT (.clk_in(clk_in),
    .rst_in(rst_in), .heat_out_in(heat), .ct_valid_in(valid), .ct1_current_in(ct1),
    .ct2_current_in(ct2), .thr_load_in(load), .thr1_in(thr1), .thr2_in(thr2),
    .alarm1_assigned_in(asg), .burnout_detect_enable_in(en_b),
    .overcurrent_enable_in(en_o), .leakage_enable_in(en_l), .burnout_alarm_out(ba),
    .overcurrent_alarm_out(oa), .leakage_short_alarm_out(la), .heater_alarm_lamp_out(lamp),
    .heater_mon_flash_out(hf), .leak_mon_flash_out(lf), .heater_current1_out(h1),
    .heater_current2_out(h2), .leakage_current1_out(l1), .leakage_current2_out(l2));

  // single transformer build
  hcam_monitor #(.SHORT_CYC(20), .BLINK_CYC(4), .TWO_CT(1'b0)) u_single (.clk_in(clk_in),
    .rst_in(rst_in), .heat_out_in(heat), .ct_valid_in(valid), .ct1_current_in(ct1),
    .ct2_current_in(ct2), .thr_load_in(load), .thr1_in(thr1), .thr2_in(thr2),
    .alarm1_assigned_in(asg), .burnout_detect_enable_in(en_b),
    .overcurrent_enable_in(en_o), .leakage_enable_in(en_l), .burnout_alarm_out(ba2),
    .overcurrent_alarm_out(oa2), .leakage_short_alarm_out(), .heater_alarm_lamp_out(),
    .heater_mon_flash_out(), .leak_mon_flash_out(), .heater_current1_out(),
    .heater_current2_out(hs2), .leakage_current1_out(), .leakage_current2_out());

  task chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task run(input logic h, input int n);
    heat = h;
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // collect seen flash levels over n cycles
  task watch(input int n);
    fo = 2'b00;
    fa = 2'b11;
    lo = 2'b00;
    lz = 2'b11;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      fo = fo | hf;
      fa = fa & hf;
      lo = lo | lf;
      lz = lz & lf;
    end
  endtask

  task test_done;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    test_done;
  end

  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    chk(al, 16'h0000);
    chk(h1, 16'h0000);
    on_v = {16'h01F4, 16'h01F4};
    run(1'b1, 30);
    run(1'b0, 2);
    chk(al, 16'h0000);
    run(1'b0, 28);
    thr1 = '{9'h064, 9'h12C, 9'h032};
    thr2 = '{9'h1F4, 9'h000, 9'h000};
    load = 1'b1;
    on_v = {16'h00C8, 16'h0050};
    off_v = {16'h0014, 16'h003C};
    run(1'b1, 30);
    chk(h1, 16'h0050);
    chk(h2, 16'h00C8);
    run(1'b0, 2);
    chk(al, 16'h0078);
    chk({14'h0000, ba2}, 16'h0001);
    chk({14'h0000, oa2}, 16'h0000);
    chk(hs2, 16'h0000);
    run(1'b0, 28);
    chk(l1, 16'h003C);
    chk(l2, 16'h0014);
    on_v[0] = 16'h0190;
    run(1'b1, 2);
    chk(al, 16'h007B);
    run(1'b1, 8);
    run(1'b0, 2);
    chk(al, 16'h007B);
    off_v[0] = 16'h0000;
    run(1'b0, 8);
    on_v[0] = 16'h0258;
    run(1'b1, 2);
    chk(al, 16'h007B);
    run(1'b1, 28);
    chk(h1, 16'hFFFF);
    run(1'b0, 2);
    chk(al, 16'h006F);
    watch(8);
    chk({12'h000, fo, fa}, 16'h000C);
    chk({12'h000, lo, lz}, 16'h000C);
    en_b = 1'b0;
    run(1'b0, 2);
    chk(al, 16'h004F);
    en_o = 1'b0;
    en_l = 1'b0;
    run(1'b0, 2);
    chk(al, 16'h0000);
    chk(l1, 16'h0000);
    asg = 1'b0;
    en_b = 1'b1;
    en_o = 1'b1;
    en_l = 1'b1;
    run(1'b1, 30);
    run(1'b0, 2);
    chk(al, 16'h0000);
    asg = 1'b1;
    run(1'b0, 28);
    run(1'b1, 30);
    run(1'b0, 2);
    chk({12'h000, ba, oa}, 16'h000B);
    test_done;
  end
endmodule
